// [iasp_bank.sv]
// alarm status and priority register bank for the clock-input selector
`timescale 1ns/1ns
`include "iasp_defines.svh"
module iasp_bank
    import iasp_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  iasp_req_t       req_i,
    input  iasp_alarm_t     alarm_i,
    input  wire logic [3:0] standby_priority_i,
    output logic [7:0]      rdata_o,
    output iasp_pri_pair_t  se_priority_o,
    output iasp_pri_pair_t  diff_priority_o,
    output iasp_sel_t       sel_o
);
    iasp_state_t st;
    iasp_state_t next_st;
    iasp_sel_t   rank;
    logic [7:0]  sb_pad;

    // order: first se, second se, first diff, second diff, stand-by
    iasp_ranker u_rank (
        .pri_i ({standby_priority_i, st.diff_pri.second, st.diff_pri.first,
                 st.se_pri.second, st.se_pri.first}),
        .ok_i  (~(st.sync2.no_act | st.sync2.no_lock)),
        .sel_o (rank)
    );

    always_comb begin
        next_st       = st;
        sb_pad        = 8'h00;
        // alarms come from other logic and pass two flops first
        next_st.sync1 = alarm_i;
        next_st.sync2 = st.sync1;
        // status follows present alarms every cycle
        next_st.se_sts = 8'h00;
        next_st.se_sts[`IASP_BIT_ACT2]  = st.sync2.no_act[1];
        next_st.se_sts[`IASP_BIT_ACT1]  = st.sync2.no_act[0];
        next_st.se_sts[`IASP_BIT_LOCK2] = st.sync2.no_lock[1];
        next_st.se_sts[`IASP_BIT_LOCK1] = st.sync2.no_lock[0];
        next_st.diff_sts = 8'h00;
        next_st.diff_sts[`IASP_BIT_ACT2]  = st.sync2.no_act[3];
        next_st.diff_sts[`IASP_BIT_ACT1]  = st.sync2.no_act[2];
        next_st.diff_sts[`IASP_BIT_LOCK2] = st.sync2.no_lock[3];
        next_st.diff_sts[`IASP_BIT_LOCK1] = st.sync2.no_lock[2];
        sb_pad[`IASP_BIT_ACT1]  = st.sync2.no_act[4];
        sb_pad[`IASP_BIT_LOCK1] = st.sync2.no_lock[4];
        next_st.sb_sts = sb_pad;
        if (req_i.wr) begin
            unique case (req_i.addr)
                `IASP_ADDR_SE_PRI: begin
                    next_st.se_pri = req_i.wdata;
                    if (req_i.wdata[7:4] != 4'h0) begin
                        next_st.diff_pri.second = 4'h0;
                    end
                    if (req_i.wdata[3:0] != 4'h0) begin
                        next_st.diff_pri.first = 4'h0;
                    end
                end
                `IASP_ADDR_DIFF_PRI: begin
                    next_st.diff_pri = req_i.wdata;
                    if (req_i.wdata[7:4] != 4'h0) begin
                        next_st.se_pri.second = 4'h0;
                    end
                    if (req_i.wdata[3:0] != 4'h0) begin
                        next_st.se_pri.first = 4'h0;
                    end
                end
                default: begin
                end
            endcase
        end
        // read data is registered, valid the cycle after the address
        unique case (req_i.addr)
            `IASP_ADDR_SE_STS:   next_st.rdata = st.se_sts;
            `IASP_ADDR_DIFF_STS: next_st.rdata = st.diff_sts;
            `IASP_ADDR_SB_STS:   next_st.rdata = st.sb_sts;
            `IASP_ADDR_SE_PRI:   next_st.rdata = st.se_pri;
            `IASP_ADDR_DIFF_PRI: next_st.rdata = st.diff_pri;
            default:             next_st.rdata = 8'h00;
        endcase
        next_st.sel = rank;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st          <= '0;
            st.se_pri   <= `IASP_SE_PRI_RST;
            st.diff_pri <= `IASP_DIFF_PRI_RST;
            st.se_sts   <= `IASP_SE_STS_RST;
            st.sync1    <= '{no_act: 5'h1f, no_lock: 5'h00};
            st.sync2    <= '{no_act: 5'h1f, no_lock: 5'h00};
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o         = st.rdata;
    assign se_priority_o   = st.se_pri;
    assign diff_priority_o = st.diff_pri;
    assign sel_o           = st.sel;
endmodule : iasp_bank

// [iasp_defines.svh]
// offsets, field positions, reset values and counts of the input alarm and priority bank
// Function
// - activity alarm bit (5 second, 1 first) follows the no-activity monitor level.
// - phase-lock alarm bit (4 second, 0 first) set when lock not shown; 0 otherwise.
// - differential alarm register mirrors single-ended layout for the two differential inputs.
// - stand-by alarm register uses only bits 1 and 0, same meaning.
// - priority register: second single-ended [7:4], first single-ended [3:0], 4 bits each.
// - smaller nonzero priority value ranks higher for automatic selection.
// - priority zero excludes that input from automatic selection.
// - nonzero write to second single-ended priority zeroes second differential priority.
// - nonzero write to first single-ended priority zeroes first differential priority.
// - nonzero write to differential priority zeroes matching single-ended priority.
`ifndef IASP_DEFINES_SVH
`define IASP_DEFINES_SVH
`define IASP_ADDR_SE_STS    7'h11
`define IASP_ADDR_DIFF_STS  7'h12
`define IASP_ADDR_SB_STS    7'h14
`define IASP_ADDR_SE_PRI    7'h19
`define IASP_ADDR_DIFF_PRI  7'h1a
`define IASP_BIT_ACT2       5
`define IASP_BIT_LOCK2      4
`define IASP_BIT_ACT1       1
`define IASP_BIT_LOCK1      0
`define IASP_SE_PRI_RST     8'h32
`define IASP_DIFF_PRI_RST   8'h00
`define IASP_SE_STS_RST     8'h22
`define IASP_NUM_IN         5
`endif

// [iasp_pkg.sv]
// types of the input alarm and priority bank
package iasp_pkg;
    typedef struct packed {
        logic [3:0] second;
        logic [3:0] first;
    } iasp_pri_pair_t;
    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } iasp_req_t;
    typedef struct packed {
        logic [4:0] no_act;
        logic [4:0] no_lock;
    } iasp_alarm_t;
    typedef struct packed {
        logic [2:0] idx;
        logic       valid;
    } iasp_sel_t;
    typedef struct packed {
        iasp_pri_pair_t se_pri;
        iasp_pri_pair_t diff_pri;
        logic [7:0]     se_sts;
        logic [7:0]     diff_sts;
        logic [7:0]     sb_sts;
        logic [7:0]     rdata;
        iasp_sel_t      sel;
        iasp_alarm_t    sync1;
        iasp_alarm_t    sync2;
    } iasp_state_t;
endpackage : iasp_pkg

// [iasp_ranker.sv]
// combinational ranking of input priorities for automatic selection
`timescale 1ns/1ns
`include "iasp_defines.svh"
module iasp_ranker
    import iasp_pkg::*;
(
    input  wire logic [19:0] pri_i,
    input  wire logic [4:0]  ok_i,
    output iasp_sel_t        sel_o
);
    logic [3:0] best;
    always_comb begin
        best  = 4'hf;
        sel_o = '0;
        for (int i = 0; i < `IASP_NUM_IN; i++) begin
            // zero priority never competes; strictly smaller wins, ties keep lower index
            if (ok_i[i] && pri_i[i*4 +: 4] != 4'h0 &&
                (!sel_o.valid || pri_i[i*4 +: 4] < best)) begin
                best      = pri_i[i*4 +: 4];
                sel_o.idx = 3'(i);
                sel_o.valid = 1'b1;
            end
        end
    end
endmodule : iasp_ranker

// [iasp_bank_props.sv]
// assertions on the ports of the alarm and priority bank
`timescale 1ns/1ns
module iasp_bank_props
    import iasp_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       arst_n_i,
    input iasp_req_t       req_i,
    input iasp_alarm_t     alarm_i,
    input wire logic [3:0] standby_priority_i,
    input wire logic [7:0] rdata_o,
    input iasp_pri_pair_t  se_priority_o,
    input iasp_pri_pair_t  diff_priority_o,
    input iasp_sel_t       sel_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    wire [19:0] pv = {standby_priority_i, diff_priority_o, se_priority_o};
    wire        w19 = req_i.wr && req_i.addr == 7'h19;
    wire        w1a = req_i.wr && req_i.addr == 7'h1a;
    wire [4:0]  a = alarm_i.no_act;
    wire [4:0]  l = alarm_i.no_lock;
    se_write_a: assert property (w19 |=> se_priority_o == $past(req_i.wdata))
        else $error("priority write lost");
    diff_hi_clr_a: assert property (w19 && req_i.wdata[7:4] != 0 |=> diff_priority_o.second == 0)
        else $error("second diff not cleared");
    diff_lo_clr_a: assert property (w19 && req_i.wdata[3:0] != 0 |=> diff_priority_o.first == 0)
        else $error("first diff not cleared");
    se_hi_clr_a: assert property (w1a && req_i.wdata[7:4] != 0 |=> se_priority_o.second == 0)
        else $error("second se not cleared");
    se_lo_clr_a: assert property (w1a && req_i.wdata[3:0] != 4'h0 |=> se_priority_o.first == 4'h0)
        else $error("first se not cleared");
    se_sts_a: assert property ((req_i.addr == 7'h11 && $stable(alarm_i))[*7]
        |-> rdata_o == {2'h0, a[1], l[1], 2'h0, a[0], l[0]}) else $error("se status wrong");
    diff_sts_a: assert property ((req_i.addr == 7'h12 && $stable(alarm_i))[*7]
        |-> rdata_o == {2'h0, a[3], l[3], 2'h0, a[2], l[2]}) else $error("diff status wrong");
    sb_sts_a: assert property ((req_i.addr == 7'h14 && $stable(alarm_i))[*7]
        |-> rdata_o == {6'h00, a[4], l[4]}) else $error("standby status wrong");
    sel_pri_a: assert property ((sel_o.valid && $stable(pv))[*2] |-> pv[sel_o.idx*4+:4] != 0)
        else $error("zero priority selected");
endmodule : iasp_bank_props
bind iasp_bank iasp_bank_props PROPS(.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req_i), .alarm_i(alarm_i),
    .standby_priority_i(standby_priority_i), .rdata_o(rdata_o), .se_priority_o(se_priority_o),
    .diff_priority_o(diff_priority_o), .sel_o(sel_o));

// [iasp_host.sv]
// host model issuing register requests on the falling edge
`timescale 1ns/1ns
module iasp_host
    import iasp_pkg::*;
(
    input  wire logic clk_i,
    output iasp_req_t req_o
);
    initial req_o = '0;
    task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req_o = '{w, a, d};
        @(negedge clk_i);
        req_o.wr = 1'b0;
    endtask : access
endmodule : iasp_host

// [input_alarm_status_and_priority_tb.sv]
// self-checking bench of the alarm and priority bank
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("BAD %0t %h %h", $time, g, e); end end
module input_alarm_status_and_priority_tb;
    import iasp_pkg::*;
    logic clk_i = 0, arst_n_i = 0;
    logic [3:0] sb = 0;
    logic [15:0] r = 16'h7c91;
    logic [7:0] rd, se = 8'h32, df = 0, d, m;
    logic [6:0] ad;
    logic [6:0] sa [3] = '{7'h11, 7'h12, 7'h14};
    iasp_req_t req;
    iasp_alarm_t al = '0;
    iasp_pri_pair_t se_o, df_o;
    iasp_sel_t sel;
    int error_cnt = 0, n_compared = 0;
    always #4 clk_i = ~clk_i;
    iasp_host HOST(.clk_i(clk_i), .req_o(req));
    iasp_bank DUT(.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req), .alarm_i(al), .standby_priority_i(sb),
        .rdata_o(rd), .se_priority_o(se_o), .diff_priority_o(df_o), .sel_o(sel));
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nx
    function automatic logic [7:0] st(input int h, input int l);
        return {2'h0, al.no_act[h], al.no_lock[h], 2'h0, al.no_act[l], al.no_lock[l]};
    endfunction : st
    // lowest nonzero unalarmed priority wins, strict compare keeps the lower index on ties
    function automatic logic [3:0] best(input logic [19:0] p);
        logic [3:0] bv = 0;
        logic [2:0] bi = 0;
        for (int i = 0; i < 5; i++)
            if (p[i*4+:4] != 0 && !(al.no_act[i] | al.no_lock[i]) && (bv == 0 || p[i*4+:4] < bv)) begin
                bv = p[i*4+:4];
                bi = 3'(i);
            end
        return {bi, bv != 0};
    endfunction : best
    task automatic chk_rd(input logic [6:0] a, input logic [7:0] e);
        HOST.access(0, a, 0);
        `CHK(rd, e)
    endtask : chk_rd
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    initial begin
        repeat (8) @(negedge clk_i);
        arst_n_i = 1;
        `CHK({se_o, df_o}, 16'h3200)
        chk_rd(7'h11, 8'h22);
        chk_rd(7'h19, 8'h32);
        $display("reset test done");
        for (int i = 0; i < 40; i++) begin
            r = nx(r);
            d = i == 0 ? 8'h00 : i == 1 ? 8'hff : r[7:0];
            ad = i == 0 ? 7'h19 : i == 1 ? 7'h1a : r[9] ? (r[8] ? 7'h11 : 7'h1a) : 7'h19;
            al = i[0] ? r[15:6] : '0;
            sb = r[3:0];
            m = ~{{4{|d[7:4]}}, {4{|d[3:0]}}};
            if (ad == 7'h19) begin
                se = d;
                df &= m;
            end
            if (ad == 7'h1a) begin
                df = d;
                se &= m;
            end
            HOST.access(1, ad, d);
            HOST.access(0, sa[i%3], 0);
            repeat (7) @(negedge clk_i);
            `CHK({se_o, df_o}, {se, df})
            `CHK({sel.valid ? sel.idx : 3'h0, sel.valid}, best({sb, df, se}))
            chk_rd(7'h11, st(1, 0));
            chk_rd(7'h12, st(3, 2));
            chk_rd(7'h14, st(4, 4) & 8'h03);
            chk_rd(7'h19, se);
            chk_rd(7'h1a, df);
        end
        $display("random test done");
        complete_run();
    end
    // about 850 cycles expected, limit leaves wide margin
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
endmodule : input_alarm_status_and_priority_tb
